/* rtl/bcc_consts.svh */
`ifndef BCC_CONSTS_SVH
`define BCC_CONSTS_SVH

// register offsets
`define BCC_OFS_CONTROL 8'h84
`define BCC_OFS_FLASH_STATUS 8'hAC
`define BCC_OFS_TUNING 8'hC9
`define BCC_OFS_LOCK 8'hD2
`define BCC_OFS_MISS_ACC 8'hD3

// reset values
`define BCC_RST_CONTROL 8'hE6
`define BCC_RST_TUNING 4'h4
`define BCC_RST_SLOT_PTR 5'h1F

// cache_control fields
`define BCC_CTL_WREN 7
`define BCC_CTL_RDEN 6
`define BCC_CTL_PFEN 5
`define BCC_CTL_FLUSH 4
`define BCC_CTL_RETI 3
`define BCC_CTL_ISR 2
`define BCC_CTL_MOVC 1
`define BCC_CTL_BLKW 0
`define BCC_CTL_STORE_MASK 8'hEF

// cache_tuning fields
`define BCC_TUN_ALG 3
`define BCC_TUN_FIX 2
`define BCC_TUN_THR_HI 1
`define BCC_TUN_THR_LO 0

// cache_lock_control fields
`define BCC_LCK_PUSH 7
`define BCC_LCK_POP 6

// cache_miss_accumulator fields
`define BCC_ACC_W 12
`define BCC_ACC_HI_LSB 5
`define BCC_ACC_LOW_CLR 5'h00
`define BCC_ACC_ONES 12'hFFF
`define BCC_ACC_ONE 12'h001

// slot geometry and counters
`define BCC_SLOT_ZERO 5'h00
`define BCC_SLOT_ONE 5'h01
`define BCC_SLOT_LAST 5'h1F
`define BCC_STALL_MAX 3'h7
`define BCC_STALL_ONE 3'h1
`define BCC_STALL_ZERO 3'h0
`define BCC_LFSR_SEED 8'hA5
`define BCC_ZERO8 8'h00

`endif

/* rtl/bcc_pkg.sv */
package bcc_pkg;
  // rebound replacement sweep direction
  typedef enum logic [1:0] {
    BCC_REB_UP = 2'b01,
    BCC_REB_DOWN = 2'b10
  } bcc_reb_dir_t;
endpackage

/* rtl/bcc_top.sv */
// Overview of operation
// - write enable off blocks normal fills
// - read enable off forces flash fetch
// - prefetch runs only while enabled
// - flush write empties cache, reads zero
// - interrupt return targets cached only enabled
// - interrupt routine code cached only enabled
// - table lookup data cached only enabled, unless pushed
// - block write bit groups flash bytes
// - select rebound or pseudo-random victim
// - fixed bit sends normal lookup fills slot zero
// - normal fill only when stall exceeds threshold
// - push locks segment, decrements slot pointer
// - slots above pointer protected unless zero
// - pop write increments pointer, reads zero
// - accumulator counts stalled miss cycles
// - overflow flag sticks until next write
// - upper write clears low; read latches
// - busy flag reads flash write state
// - rebound sweeps up then down
// - flash modify always invalidates bytes
`timescale 1ns/1ps
`default_nettype none
`include "bcc_consts.svh"

module bcc_top #(
  parameter int SLOT_BITS = 5,
  parameter int ADDR_W = 16
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic fetch_stall,
  input wire logic fill_valid,
  input wire logic fill_is_reti,
  input wire logic fill_is_isr,
  input wire logic fill_is_movc,
  input wire logic flash_busy,
  input wire logic flash_modify,
  input wire logic [ADDR_W-1:0] flash_modify_addr,
  output logic cache_fill,
  output logic cache_lock_write,
  output logic [SLOT_BITS-1:0] cache_fill_slot,
  output logic cache_flush,
  output logic cache_invalidate,
  output logic [ADDR_W-1:0] cache_invalidate_addr,
  output logic cache_read_enable,
  output logic prefetch_enable,
  output logic flash_block_write
);

  // the slot pointer and field layout are fixed at five bits
  generate
    if (SLOT_BITS != 5) begin : g_bad_slots
      $error("bcc_top: SLOT_BITS must be 5");
    end
    if (ADDR_W < 2) begin : g_bad_addr
      $error("bcc_top: ADDR_W too small");
    end
  endgenerate

  logic [7:0] ctrl;
  logic [3:0] tune;
  logic push_en;
  logic [4:0] slot_ptr;
  logic [`BCC_ACC_W-1:0] acc;
  logic acc_ov;
  logic [3:0] acc_low_latch;
  logic busy_q;
  logic [2:0] stall_cnt;
  logic [7:0] lfsr;
  logic [4:0] reb_slot;
  bcc_pkg::bcc_reb_dir_t reb_dir;

  // reset image of cache_control, named so single bits can be picked out
  localparam logic [7:0] CTRL_RST = `BCC_RST_CONTROL;

  // decoded strobes
  logic wr_ctrl, wr_tune, wr_lock, wr_acc, rd_acc;
  assign wr_ctrl = reg_wr && (reg_addr == `BCC_OFS_CONTROL);
  assign wr_tune = reg_wr && (reg_addr == `BCC_OFS_TUNING);
  assign wr_lock = reg_wr && (reg_addr == `BCC_OFS_LOCK);
  assign wr_acc = reg_wr && (reg_addr == `BCC_OFS_MISS_ACC);
  assign rd_acc = reg_rd && (reg_addr == `BCC_OFS_MISS_ACC);

  logic pop_ev, push_ev, flush_req;
  assign pop_ev = wr_lock && reg_wdata[`BCC_LCK_POP];
  assign flush_req = wr_ctrl && reg_wdata[`BCC_CTL_FLUSH];
  assign push_ev = fill_valid && fill_is_movc && push_en;

  // cache_control storage; flush bit is never stored
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl <= `BCC_RST_CONTROL;
    end else if (wr_ctrl) begin
      ctrl <= reg_wdata & `BCC_CTL_STORE_MASK;
    end
  end

  // control bits that steer the cache and flash straight out
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cache_read_enable <= CTRL_RST[`BCC_CTL_RDEN];
      prefetch_enable <= CTRL_RST[`BCC_CTL_PFEN];
      flash_block_write <= CTRL_RST[`BCC_CTL_BLKW];
    end else if (wr_ctrl) begin
      cache_read_enable <= reg_wdata[`BCC_CTL_RDEN];
      prefetch_enable <= reg_wdata[`BCC_CTL_PFEN];
      flash_block_write <= reg_wdata[`BCC_CTL_BLKW];
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cache_flush <= 1'b0;
    end else begin
      cache_flush <= flush_req;
    end
  end

  // flash change invalidates regardless of write enable
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cache_invalidate <= 1'b0;
      cache_invalidate_addr <= '0;
    end else begin
      cache_invalidate <= flash_modify;
      if (flash_modify) begin
        cache_invalidate_addr <= flash_modify_addr;
      end
    end
  end

  // tuning low nibble; the upper nibble is the latched accumulator
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      tune <= `BCC_RST_TUNING;
    end else if (wr_tune) begin
      tune <= reg_wdata[3:0];
    end
  end

  // push enable bit
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      push_en <= 1'b0;
    end else if (wr_lock) begin
      push_en <= reg_wdata[`BCC_LCK_PUSH];
    end
  end

  // lock stack pointer; push and pop together cancel out
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      slot_ptr <= `BCC_RST_SLOT_PTR;
    end else if (push_ev && !pop_ev) begin
      slot_ptr <= slot_ptr - `BCC_SLOT_ONE;
    end else if (pop_ev && !push_ev) begin
      slot_ptr <= slot_ptr + `BCC_SLOT_ONE;
    end
  end

  // stall cycles seen since the last fill, saturating
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      stall_cnt <= `BCC_STALL_ZERO;
    end else if (fill_valid) begin
      stall_cnt <= `BCC_STALL_ZERO;
    end else if (fetch_stall && stall_cnt != `BCC_STALL_MAX) begin
      stall_cnt <= stall_cnt + `BCC_STALL_ONE;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      lfsr <= `BCC_LFSR_SEED;
    end else begin
      lfsr <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
    end
  end

  // highest replaceable slot: all slots when the pointer is zero
  logic [4:0] limit;
  assign limit = (slot_ptr == `BCC_SLOT_ZERO) ? `BCC_SLOT_LAST : slot_ptr;

  // fold the random value into the unlocked range; slight bias is accepted
  logic [4:0] rnd_slot;
  always_comb begin
    rnd_slot = lfsr[4:0];
    if (rnd_slot > limit) begin
      rnd_slot = rnd_slot - limit - `BCC_SLOT_ONE;
    end
    if (rnd_slot > limit) begin
      rnd_slot = limit;
    end
  end

  // rebound victim and next sweep position
  logic [4:0] reb_victim, next_reb_slot;
  bcc_pkg::bcc_reb_dir_t next_reb_dir;
  always_comb begin
    reb_victim = (reb_slot > limit) ? limit : reb_slot;
    next_reb_slot = reb_victim;
    next_reb_dir = reb_dir;
    case (reb_dir)
      bcc_pkg::BCC_REB_UP: begin
        if (reb_victim >= limit) begin
          next_reb_dir = bcc_pkg::BCC_REB_DOWN;
          next_reb_slot = (reb_victim == `BCC_SLOT_ZERO) ? reb_victim : reb_victim - `BCC_SLOT_ONE;
        end else begin
          next_reb_slot = reb_victim + `BCC_SLOT_ONE;
        end
      end
      bcc_pkg::BCC_REB_DOWN: begin
        if (reb_victim == `BCC_SLOT_ZERO) begin
          next_reb_dir = bcc_pkg::BCC_REB_UP;
          next_reb_slot = (limit == `BCC_SLOT_ZERO) ? reb_victim : `BCC_SLOT_ONE;
        end else begin
          next_reb_slot = reb_victim - `BCC_SLOT_ONE;
        end
      end
      default: begin
        next_reb_dir = bcc_pkg::BCC_REB_UP;
        next_reb_slot = `BCC_SLOT_ZERO;
      end
    endcase
  end

  // fill qualification
  logic cacheable, use_fixed, alg_fill;
  always_comb begin
    cacheable = fill_valid && ctrl[`BCC_CTL_WREN];
    cacheable = cacheable && (stall_cnt > {1'b0, tune[`BCC_TUN_THR_HI:`BCC_TUN_THR_LO]});
    cacheable = cacheable && (!fill_is_reti || ctrl[`BCC_CTL_RETI]);
    cacheable = cacheable && (!fill_is_isr || ctrl[`BCC_CTL_ISR]);
    cacheable = cacheable && (!fill_is_movc || ctrl[`BCC_CTL_MOVC]);
    use_fixed = fill_is_movc && tune[`BCC_TUN_FIX];
    alg_fill = cacheable && !push_ev && !use_fixed && !tune[`BCC_TUN_ALG];
  end

  // rebound position only moves when it actually chose a victim
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      reb_slot <= `BCC_SLOT_ZERO;
      reb_dir <= bcc_pkg::BCC_REB_UP;
    end else if (alg_fill) begin
      reb_slot <= next_reb_slot;
      reb_dir <= next_reb_dir;
    end
  end

  // cache write command; a push outranks a plain fill
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cache_fill <= 1'b0;
      cache_lock_write <= 1'b0;
      cache_fill_slot <= `BCC_SLOT_ZERO;
    end else begin
      cache_fill <= push_ev || cacheable;
      cache_lock_write <= push_ev;
      // slot holds between writes so the cache side may sample it late
      if (push_ev) begin
        cache_fill_slot <= slot_ptr;
      end else if (cacheable && use_fixed) begin
        cache_fill_slot <= `BCC_SLOT_ZERO;
      end else if (cacheable) begin
        cache_fill_slot <= tune[`BCC_TUN_ALG] ? rnd_slot : reb_victim;
      end
    end
  end

  // miss penalty accumulator
  logic acc_wrap;
  assign acc_wrap = fetch_stall && !wr_acc && (acc == `BCC_ACC_ONES);
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      acc <= '0;
    end else if (wr_acc) begin
      acc <= {reg_wdata[6:0], `BCC_ACC_LOW_CLR};
    end else if (fetch_stall) begin
      acc <= acc + `BCC_ACC_ONE;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      acc_ov <= 1'b0;
    end else begin
      acc_ov <= acc_wrap || (acc_ov && !wr_acc);
    end
  end

  // low field latched by upper read
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      acc_low_latch <= 4'h0;
    end else if (rd_acc) begin
      acc_low_latch <= acc[4:1];
    end
  end

  // flash busy comes from the flash sequencer on this clock
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      busy_q <= 1'b0;
    end else begin
      busy_q <= flash_busy;
    end
  end

  // read data valid only in the cycle after the strobe
  logic [7:0] next_rdata;
  always_comb begin
    next_rdata = `BCC_ZERO8;
    if (reg_rd) begin
      case (reg_addr)
        `BCC_OFS_CONTROL: next_rdata = ctrl;
        `BCC_OFS_FLASH_STATUS: next_rdata = {7'h00, busy_q};
        `BCC_OFS_TUNING: next_rdata = {acc_low_latch, tune};
        `BCC_OFS_LOCK: next_rdata = {push_en, 2'b00, slot_ptr};
        `BCC_OFS_MISS_ACC: next_rdata = {acc_ov, acc[`BCC_ACC_W-1:`BCC_ACC_HI_LSB]};
        default: next_rdata = `BCC_ZERO8;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= `BCC_ZERO8;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

  property p_flush_pulse;
    @(posedge sys_clk) disable iff (!resetn)
    flush_req |=> cache_flush ##1 (!cache_flush || $past(flush_req));
  endproperty
  a_flush_pulse: assert property (p_flush_pulse) else $error("flush pulse wrong");

  property p_flush_reads_zero;
    @(posedge sys_clk) disable iff (!resetn)
    (reg_rd && reg_addr == 8'h84) |=> !reg_rdata[4];
  endproperty
  a_flush_reads_zero: assert property (p_flush_reads_zero) else $error("flush bit read nonzero");

  property p_no_fill_when_disabled;
    @(posedge sys_clk) disable iff (!resetn)
    (fill_valid && !ctrl[7] && !push_ev) |=> !cache_fill;
  endproperty
  a_no_fill_when_disabled: assert property (p_no_fill_when_disabled) else $error("fill with writes off");

  property p_threshold;
    @(posedge sys_clk) disable iff (!resetn)
    (fill_valid && !push_ev && stall_cnt <= {1'b0, tune[1:0]}) |=> !cache_fill;
  endproperty
  a_threshold: assert property (p_threshold) else $error("fill below threshold");

  property p_push;
    @(posedge sys_clk) disable iff (!resetn)
    (push_ev && !pop_ev) |=> cache_lock_write && cache_fill_slot == $past(slot_ptr)
      && slot_ptr == $past(slot_ptr) - 5'h01;
  endproperty
  a_push: assert property (p_push) else $error("push slot or pointer wrong");

  property p_pop;
    @(posedge sys_clk) disable iff (!resetn)
    (pop_ev && !push_ev) |=> slot_ptr == $past(slot_ptr) + 5'h01;
  endproperty
  a_pop: assert property (p_pop) else $error("pop did not step pointer");

  property p_fixed_slot;
    @(posedge sys_clk) disable iff (!resetn)
    (cacheable && !push_ev && fill_is_movc && tune[2]) |=> cache_fill && cache_fill_slot == 5'h00;
  endproperty
  a_fixed_slot: assert property (p_fixed_slot) else $error("lookup fill not slot zero");

  property p_locked_safe;
    @(posedge sys_clk) disable iff (!resetn)
    (cacheable && !push_ev && slot_ptr != 5'h00) |=> cache_fill_slot <= $past(slot_ptr);
  endproperty
  a_locked_safe: assert property (p_locked_safe) else $error("fill hit locked slot");

  property p_acc_count;
    @(posedge sys_clk) disable iff (!resetn)
    (fetch_stall && !wr_acc) |=> acc == $past(acc) + 12'h001;
  endproperty
  a_acc_count: assert property (p_acc_count) else $error("accumulator missed stall");

  property p_overflow;
    @(posedge sys_clk) disable iff (!resetn)
    acc_wrap |=> acc_ov ##1 (acc_ov || $past(wr_acc));
  endproperty
  a_overflow: assert property (p_overflow) else $error("overflow not sticky");

  property p_acc_write;
    @(posedge sys_clk) disable iff (!resetn)
    wr_acc |=> acc[4:0] == 5'h00 && acc[11:5] == $past(reg_wdata[6:0]);
  endproperty
  a_acc_write: assert property (p_acc_write) else $error("upper write wrong");

  property p_busy_read;
    @(posedge sys_clk) disable iff (!resetn)
    (reg_rd && reg_addr == 8'hAC) |=> reg_rdata == {7'h00, $past(busy_q)};
  endproperty
  a_busy_read: assert property (p_busy_read) else $error("busy read wrong");

endmodule

`default_nettype wire

/* bench/bcc_far_model.sv */
`timescale 1ns/1ps
`default_nettype none
module bcc_far_model (
  input wire logic sys_clk,
  output logic fetch_stall,
  output logic fill_valid,
  output logic fill_is_reti,
  output logic fill_is_isr,
  output logic fill_is_movc,
  output logic flash_busy,
  output logic flash_modify,
  output logic [15:0] flash_modify_addr
);
  // idle qualifiers are not held at zero, so a fill never leans on stale values
  initial begin
    fetch_stall = 1'b0;
    fill_valid = 1'b0;
    {fill_is_reti, fill_is_isr, fill_is_movc} = 3'h5;
    flash_busy = 1'b0;
    flash_modify = 1'b0;
    flash_modify_addr = 16'hA5A5;
  end
  // core stalls n cycles on a miss, then the word arrives
  task automatic fetch(input int n, input logic [2:0] q);
    repeat (n) begin
      @(posedge sys_clk);
      fetch_stall <= 1'b1;
    end
    @(posedge sys_clk);
    fetch_stall <= 1'b0;
    fill_valid <= 1'b1;
    {fill_is_reti, fill_is_isr, fill_is_movc} <= q;
    @(posedge sys_clk);
    fill_valid <= 1'b0;
    {fill_is_reti, fill_is_isr, fill_is_movc} <= ~q;
  endtask
  // flash programming touched some bytes; address is scrambled afterwards
  task automatic modify(input logic [15:0] a);
    @(posedge sys_clk);
    flash_modify <= 1'b1;
    flash_modify_addr <= a;
    @(posedge sys_clk);
    flash_modify <= 1'b0;
    flash_modify_addr <= ~a;
  endtask
  // flash write or erase in progress
  task automatic set_busy(input logic b);
    @(posedge sys_clk);
    flash_busy <= b;
  endtask
endmodule
`default_nettype wire

/* bench/branch_cache_control_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module branch_cache_control_tb;
  logic sys_clk, resetn, reg_wr, reg_rd, rd_d;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, ctl, v;
  logic fetch_stall, fill_valid, fill_is_reti, fill_is_isr, fill_is_movc, flash_busy, flash_modify;
  logic [15:0] flash_modify_addr, cache_invalidate_addr, last_a;
  logic cache_fill, cache_lock_write, cache_flush, cache_invalidate;
  logic cache_read_enable, prefetch_enable, flash_block_write, push_m, ov, busy_m, up;
  logic [4:0] cache_fill_slot, ptr, reb;
  logic [3:0] tun, latch;
  logic [11:0] acc;
  logic [31:0] lf, r;
  logic [7:0] rq[$];
  logic [6:0] fq[$];
  logic [17:0] eq[$];
  logic [19:0] tbl [9] = '{20'hE6044, 20'hEE044, 20'hEE042, 20'hEA042, 20'hEA041, 20'hEA001, 20'hE8001,
    20'h66000, 20'hE6041};
  int failures, cmp_count;

  bcc_top #(.SLOT_BITS(5), .ADDR_W(16)) u_dut (.sys_clk(sys_clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .fetch_stall(fetch_stall),
    .fill_valid(fill_valid), .fill_is_reti(fill_is_reti), .fill_is_isr(fill_is_isr), .fill_is_movc(fill_is_movc),
    .flash_busy(flash_busy), .flash_modify(flash_modify), .flash_modify_addr(flash_modify_addr),
    .cache_fill(cache_fill), .cache_lock_write(cache_lock_write), .cache_fill_slot(cache_fill_slot),
    .cache_flush(cache_flush), .cache_invalidate(cache_invalidate), .cache_invalidate_addr(cache_invalidate_addr),
    .cache_read_enable(cache_read_enable), .prefetch_enable(prefetch_enable), .flash_block_write(flash_block_write));
  bcc_far_model u_far (.sys_clk(sys_clk), .fetch_stall(fetch_stall), .fill_valid(fill_valid),
    .fill_is_reti(fill_is_reti), .fill_is_isr(fill_is_isr), .fill_is_movc(fill_is_movc), .flash_busy(flash_busy),
    .flash_modify(flash_modify), .flash_modify_addr(flash_modify_addr));

  // 125 MHz system clock
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  function automatic logic [31:0] rnd();
    lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
    return lf;
  endfunction
  task automatic finish_test();
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic h, input logic [17:0] e, input logic [17:0] g);
    cmp_count++;
    if (!h || e !== g) begin
      failures++;
      $display("Error t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic cmp_rd(input logic [7:0] g);
    logic h;
    logic [7:0] e;
    h = rq.size() > 0;
    e = h ? rq.pop_front() : 8'h00;
    chk(h, {10'h000, e}, {10'h000, g});
  endtask
  // random-victim entries only check that a fill happened and its kind
  task automatic cmp_fill(input logic [6:0] g);
    logic h;
    logic [6:0] e;
    h = fq.size() > 0;
    e = h ? fq.pop_front() : 7'h00;
    if (e[6]) e[4:0] = g[4:0];
    chk(h, {11'h000, 1'b1, e[5:0]}, {11'h000, g});
  endtask
  task automatic cmp_evt(input logic [17:0] g);
    logic h;
    logic [17:0] e;
    h = eq.size() > 0;
    e = h ? eq.pop_front() : 18'h00000;
    chk(h, e, g);
  endtask
  task automatic cmp_lvl(input logic [17:0] e, input logic [17:0] g);
    chk(1'b1, e, g);
  endtask
  // bus strobes are left up so reads and writes run back to back
  task automatic idle();
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    logic [7:0] e;
    case (a)
      8'h84: e = ctl;
      8'hAC: e = {7'h00, busy_m};
      8'hC9: e = {latch, tun};
      8'hD2: e = {push_m, 2'b00, ptr};
      8'hD3: e = {ov, acc[11:5]};
      default: e = 8'h00;
    endcase
    if (a == 8'hD3) latch = acc[4:1];
    rq.push_back(e);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_wr <= 1'b0;
    reg_addr <= a;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    case (a)
      8'h84: begin
        ctl = d & 8'hEF;
        if (d[4]) eq.push_back({2'b10, last_a});
      end
      8'hC9: tun = d[3:0];
      8'hD2: begin
        push_m = d[7];
        if (d[6]) ptr = ptr + 5'h01;
      end
      8'hD3: begin
        acc = {d[6:0], 5'h00};
        ov = 1'b0;
      end
      default: ;
    endcase
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_rd <= 1'b0;
    reg_addr <= a;
    reg_wdata <= d;
  endtask
  // predicts the fill, victim slot and stall accumulation of one miss
  task automatic fetch(input int n, input logic [2:0] q);
    logic ok;
    logic [12:0] s;
    logic [4:0] lim;
    s = {1'b0, acc} + 13'(n);
    acc = s[11:0];
    if (s[12]) ov = 1'b1;
    ok = ctl[7] && n > tun[1:0] && !(q[2] && !ctl[3]) && !(q[1] && !ctl[2]) && !(q[0] && !ctl[1]);
    lim = (ptr == 5'h00) ? 5'h1F : ptr;
    if (push_m && q[0]) begin
      fq.push_back({2'b01, ptr});
      ptr = ptr - 5'h01;
    end else if (ok && q[0] && tun[2]) fq.push_back(7'h00);
    else if (ok && tun[3]) fq.push_back(7'h40);
    else if (ok) begin
      fq.push_back({2'b00, reb});
      if (up && reb == lim) up = 1'b0;
      else if (!up && reb == 5'h00) up = 1'b1;
      reb = up ? reb + 5'h01 : reb - 5'h01;
    end
    idle();
    u_far.fetch(n, q);
  endtask
  task automatic busy(input logic b);
    idle();
    busy_m = b;
    u_far.set_busy(b);
  endtask
  always @(posedge sys_clk) rd_d <= reg_rd;
  // watcher pairs every read, fill and flush or invalidate at the outputs with the oldest note
  always @(negedge sys_clk) begin
    if (resetn === 1'b1) begin
      if (rd_d === 1'b1) cmp_rd(reg_rdata);
      else cmp_lvl(18'h00000, {10'h000, reg_rdata});
      if (cache_fill !== 1'b0) cmp_fill({cache_fill, cache_lock_write, cache_fill_slot});
      if (cache_flush !== 1'b0 || cache_invalidate !== 1'b0)
        cmp_evt({cache_flush, cache_invalidate, cache_invalidate_addr});
    end
  end
  // a hang ends the run as a failure
  initial begin
    repeat (20000) @(posedge sys_clk);
    failures++;
    $display("Error t=%0t exp=%h got=%h", $time, 0, 1);
    finish_test();
  end
  initial begin
    {resetn, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    {ctl, tun, latch, ptr, push_m, ov, busy_m, acc, reb, up} = {8'hE6, 4'h4, 4'h0, 5'h1F, 3'h0, 12'h000, 5'h00, 1'b1};
    {last_a, failures, cmp_count, lf} = {16'h0000, 64'h0, 32'h00012624};
    repeat (5) @(posedge sys_clk);
    @(negedge sys_clk);
    cmp_lvl(18'h0000C, {6'h00, reg_rdata, cache_read_enable, prefetch_enable, flash_block_write, cache_fill});
    @(posedge sys_clk);
    resetn <= 1'b1;
    // upper field is read before the lower field
    foreach (tbl[i]) rd(i == 0 ? 8'h84 : i == 1 ? 8'hAC : i == 2 ? 8'hD3 : i == 3 ? 8'hC9 : i == 4 ? 8'hD2 : 8'h3A);
    wr(8'h3A, 8'h55);
    wr(8'hAC, 8'h01);
    rd(8'h3A);
    rd(8'hAC);
    $display("test reset values done");
    for (int t = 0; t < 4; t++) begin
      wr(8'hC9, 8'h04 | 8'(t));
      fetch(t, 3'h0);
      fetch(t + 1, 3'h0);
    end
    $display("test threshold done");
    foreach (tbl[i]) begin
      wr(8'h84, tbl[i][19:12]);
      wr(8'hC9, tbl[i][11:4]);
      fetch(2, tbl[i][2:0]);
    end
    $display("test exclusions done");
    repeat (8) begin
      r = rnd();
      v = r[7:0] & 8'hEF;
      wr(8'h84, v);
      wr(8'hC9, {5'h00, r[18:16]});
      idle();
      @(negedge sys_clk);
      cmp_lvl({15'h0000, v[6], v[5], v[0]}, {15'h0000, cache_read_enable, prefetch_enable, flash_block_write});
      fetch(int'(r[26:24]), r[30:28]);
    end
    $display("test random mix done");
    // pushes stay well under thirty; pops never outnumber pushes
    wr(8'h84, 8'hE6);
    wr(8'hC9, 8'h04);
    wr(8'hD2, 8'h80);
    fetch(3, 3'h1);
    wr(8'h84, 8'h66);
    fetch(3, 3'h1);
    // a third push keeps both pops clear of pointer 1F
    fetch(3, 3'h1);
    rd(8'hD2);
    wr(8'hD2, 8'h40);
    wr(8'hD2, 8'h40);
    rd(8'hD2);
    $display("test lock stack done");
    wr(8'h84, 8'hE6);
    wr(8'hD3, 8'h7F);
    fetch(32, 3'h0);
    fetch(3, 3'h0);
    rd(8'hD3);
    rd(8'hC9);
    wr(8'hD3, 8'h05);
    fetch(7, 3'h0);
    rd(8'hD3);
    rd(8'hC9);
    $display("test accumulator done");
    wr(8'h84, 8'h66);
    r = rnd();
    last_a = r[15:0];
    eq.push_back({2'b01, last_a});
    idle();
    u_far.modify(last_a);
    busy(1'b1);
    wr(8'hAC, 8'h01);
    rd(8'hAC);
    busy(1'b0);
    rd(8'hAC);
    wr(8'h84, 8'hF6);
    rd(8'h84);
    wr(8'hC9, 8'h08);
    fetch(2, 3'h0);
    fetch(2, 3'h0);
    $display("test flash flush random done");
    idle();
    repeat (4) @(posedge sys_clk);
    if (rq.size() + fq.size() + eq.size() != 0) begin
      failures++;
      $display("Error t=%0t exp=%h got=%h", $time, 0, rq.size() + fq.size() + eq.size());
    end
    finish_test();
  end
endmodule
`default_nettype wire
